/* File: tbi_pkg.sv */
`default_nettype none

package tbi_pkg;

  // ----------------------------------------
  // Code-group layout
  // ----------------------------------------
  localparam int GROUP_W     = 10;
  localparam int HALF_W      = 5;
  localparam int NIB_W       = 4;
  localparam int CTL_LO_BIT  = 4;
  localparam int HI_NIB_LSB  = 5;
  localparam int CTL_HI_BIT  = 9;
  localparam int STRAP_W     = 3;
  localparam int CNT_W       = 8;
  localparam int COMMA_W     = 7;
  localparam logic [COMMA_W-1:0] COMMA_PLUS  = 7'h7c;
  localparam logic [COMMA_W-1:0] COMMA_MINUS = 7'h03;

  // ----------------------------------------
  // Strap patterns
  // ----------------------------------------
  localparam logic [STRAP_W-1:0] STRAP_FULL    = 3'h1;
  localparam logic [STRAP_W-1:0] STRAP_REDUCED = 3'h5;
  localparam logic [STRAP_W-1:0] STRAP_RED_ALT = 3'h7;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CORE_CLK_PERIOD_PS    = 10000;
  localparam int TX_CLK_PERIOD_PS      = 8000;
  localparam int RX_FULL_CLK_PERIOD_PS = 16000;
  localparam int RX_RED_CLK_PERIOD_PS  = 8000;
  // Mid-phase launch needs at least two cycles per half period
  localparam int MIN_HALF_CYCLES       = 2;
  localparam int TX_HALF_RAW      = TX_CLK_PERIOD_PS / (2 * CORE_CLK_PERIOD_PS);
  localparam int RX_FULL_HALF_RAW = RX_FULL_CLK_PERIOD_PS / (2 * CORE_CLK_PERIOD_PS);
  localparam int RX_RED_HALF_RAW  = RX_RED_CLK_PERIOD_PS / (2 * CORE_CLK_PERIOD_PS);
  localparam int TX_HALF_CYCLES      = (TX_HALF_RAW < MIN_HALF_CYCLES) ? MIN_HALF_CYCLES : TX_HALF_RAW;
  localparam int RX_FULL_HALF_CYCLES = (RX_FULL_HALF_RAW < MIN_HALF_CYCLES) ? MIN_HALF_CYCLES : RX_FULL_HALF_RAW;
  localparam int RX_RED_HALF_CYCLES  = (RX_RED_HALF_RAW < MIN_HALF_CYCLES) ? MIN_HALF_CYCLES : RX_RED_HALF_RAW;

  typedef enum logic [1:0]
  {
    PORT_OFF     = 2'h0,
    PORT_FULL    = 2'h1,
    PORT_REDUCED = 2'h3
  } port_mode_t;

  function automatic port_mode_t mode_from_strap(input logic [STRAP_W-1:0] strap);
    if (strap == STRAP_FULL)
    begin
      return PORT_FULL;
    end
    else if ((strap == STRAP_REDUCED) || (strap == STRAP_RED_ALT))
    begin
      return PORT_REDUCED;
    end
    return PORT_OFF;
  endfunction

  function automatic logic comma_seen(input logic [GROUP_W-1:0] grp);
    return (grp[COMMA_W-1:0] == COMMA_PLUS) || (grp[COMMA_W-1:0] == COMMA_MINUS);
  endfunction

endpackage

`default_nettype wire

/* File: tbi_link_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface tbi_link_if;
  logic                         tenbit_tx_clock;
  logic [tbi_pkg::GROUP_W-1:0]  tx_data;
  logic                         tx_ctl;
  logic                         odd_group_rx_clock;
  logic                         even_group_rx_clock;
  logic [tbi_pkg::GROUP_W-1:0]  rx_data;
  logic                         rx_ctl;
  logic                         comma;

  modport device
  (
    input  tenbit_tx_clock,
    input  tx_data,
    input  tx_ctl,
    output odd_group_rx_clock,
    output even_group_rx_clock,
    output rx_data,
    output rx_ctl,
    output comma
  );

  modport mac
  (
    output tenbit_tx_clock,
    output tx_data,
    output tx_ctl,
    input  odd_group_rx_clock,
    input  even_group_rx_clock,
    input  rx_data,
    input  rx_ctl,
    input  comma
  );
endinterface

`default_nettype wire

/* File: neg_capture.sv */
`timescale 1ns/1ps
`default_nettype none

module neg_capture #(
  parameter int W = 5
)(
  input  wire logic          clk,
  input  wire logic          reset_link,
  input  wire logic [W-1:0]  d,
  output logic      [W-1:0]  q
);
  import tbi_pkg::*;

  typedef struct packed
  {
    logic [W-1:0] q;
  } neg_state_t;

  neg_state_t s_r;
  neg_state_t s_nxt;

  always_comb
  begin
    s_nxt   = s_r;
    s_nxt.q = d;
    if (reset_link)
    begin
      s_nxt.q = '0;
    end
  end

  // Falling-edge half of a double-rate pin pair
  always_ff @(negedge clk)
  begin
    s_r <= s_nxt;
  end

  assign q = s_r.q;
endmodule

`default_nettype wire

/* File: tbi_device_end.sv */
`timescale 1ns/1ps
`default_nettype none

module tbi_device_end #(
  parameter int RX_HALF_FULL = tbi_pkg::RX_FULL_HALF_CYCLES,
  parameter int RX_HALF_RED  = tbi_pkg::RX_RED_HALF_CYCLES
)(
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          core_ce,
  input  wire logic [tbi_pkg::STRAP_W-1:0]   mac_port_type_strap,
  input  wire logic                          gigabit_link,
  tbi_link_if.device                         link,
  output logic      [tbi_pkg::GROUP_W-1:0]   tx_group,
  output logic                               tx_group_valid,
  input  wire logic [tbi_pkg::GROUP_W-1:0]   rx_group,
  input  wire logic                          rx_group_valid,
  output logic                               rx_group_ready,
  output tbi_pkg::port_mode_t                port_mode
);
  import tbi_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    logic [STRAP_W-1:0] strap_s1;
    logic [STRAP_W-1:0] strap_s2;
    logic               strap_done;
    port_mode_t         mode;
    logic               gig_s1;
    logic               gig_s2;
    logic               tgl_s1;
    logic               tgl_s2;
    logic               tgl_seen;
    logic [GROUP_W-1:0] tx_group;
    logic               tx_valid;
    logic [CNT_W-1:0]   cnt;
    logic               phase;
    logic               even_clk;
    logic [GROUP_W-1:0] cur;
    logic [GROUP_W-1:0] rx_pins;
    logic               rx_ctl;
    logic               comma;
  } core_state_t;

  typedef struct packed
  {
    logic               rst_s1;
    logic               rst_s2;
    port_mode_t         mode_s1;
    port_mode_t         mode_s2;
    logic [HALF_W-1:0]  first_half;
    logic               first_ok;
    logic [GROUP_W-1:0] hold;
    logic               toggle;
  } link_state_t;

  core_state_t        c_r;
  core_state_t        c_nxt;
  link_state_t        lk_r;
  link_state_t        lk_nxt;
  logic [CNT_W-1:0]   half_c;
  logic               run;
  logic               launch;
  logic               take;
  logic [GROUP_W-1:0] rx_grp;
  logic [HALF_W-1:0]  neg_half;

  // ----------------------------------------
  // Core domain: strap, receive path, crossing
  // ----------------------------------------
  always_comb
  begin
    c_nxt  = c_r;
    half_c = (c_r.mode == PORT_FULL) ? CNT_W'(RX_HALF_FULL) : CNT_W'(RX_HALF_RED);
    run    = c_r.gig_s2 && (c_r.mode != PORT_OFF);
    launch = run && (c_r.cnt == (half_c >> 1));
    take   = launch && ((c_r.mode == PORT_FULL) || !c_r.phase);
    rx_grp = rx_group_valid ? rx_group : '0;

    c_nxt.strap_s1 = mac_port_type_strap;
    c_nxt.strap_s2 = c_r.strap_s1;
    c_nxt.gig_s1   = gigabit_link;
    c_nxt.gig_s2   = c_r.gig_s1;
    c_nxt.tgl_s1   = lk_r.toggle;
    c_nxt.tgl_s2   = c_r.tgl_s1;
    c_nxt.tx_valid = 1'b0;

    // Strap caught once, first cycle after reset release
    if (!c_r.strap_done)
    begin
      c_nxt.strap_done = 1'b1;
      c_nxt.mode       = mode_from_strap(c_r.strap_s2);
    end

    // Hold register is stable once its toggle has been seen
    if (c_r.tgl_s2 != c_r.tgl_seen)
    begin
      c_nxt.tgl_seen = c_r.tgl_s2;
      if (run)
      begin
        c_nxt.tx_group = lk_r.hold;
        c_nxt.tx_valid = 1'b1;
      end
    end

    if (!run)
    begin
      c_nxt.cnt     = '0;
      c_nxt.phase   = 1'b0;
      c_nxt.rx_pins = '0;
      c_nxt.rx_ctl  = 1'b0;
      c_nxt.comma   = 1'b0;
    end
    else
    begin
      if (c_r.cnt == (half_c - CNT_W'(1)))
      begin
        c_nxt.cnt   = '0;
        c_nxt.phase = !c_r.phase;
      end
      else
      begin
        c_nxt.cnt = c_r.cnt + CNT_W'(1);
      end
      // Launch mid-phase so data is settled at the next clock edge
      if (launch)
      begin
        if (c_r.mode == PORT_FULL)
        begin
          c_nxt.rx_pins = rx_grp;
          c_nxt.comma   = comma_seen(rx_grp);
          c_nxt.rx_ctl  = 1'b0;
        end
        else if (!c_r.phase)
        begin
          c_nxt.cur     = rx_grp;
          c_nxt.rx_pins = {{(GROUP_W-NIB_W){1'b0}}, rx_grp[NIB_W-1:0]};
          c_nxt.rx_ctl  = rx_grp[CTL_LO_BIT];
          c_nxt.comma   = 1'b0;
        end
        else
        begin
          c_nxt.rx_pins = {{(GROUP_W-NIB_W){1'b0}}, c_r.cur[HI_NIB_LSB +: NIB_W]};
          c_nxt.rx_ctl  = c_r.cur[CTL_HI_BIT];
        end
      end
    end
    c_nxt.even_clk = run && (c_r.mode == PORT_FULL) && !c_nxt.phase;

    if (reset)
    begin
      c_nxt            = '0;
      c_nxt.strap_s1   = mac_port_type_strap;
      c_nxt.strap_s2   = c_r.strap_s1;
      c_nxt.gig_s1     = gigabit_link;
      c_nxt.gig_s2     = c_r.gig_s1;
      c_nxt.tgl_s1     = lk_r.toggle;
      c_nxt.tgl_s2     = c_r.tgl_s1;
      c_nxt.tgl_seen   = c_r.tgl_s2;
      c_nxt.mode       = PORT_OFF;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset || core_ce)
    begin
      c_r <= c_nxt;
    end
  end

  // ----------------------------------------
  // Link domain: transmit capture
  // ----------------------------------------
  neg_capture #(
    .W (HALF_W)
  ) u_neg_capture (
    .clk        (link.tenbit_tx_clock),
    .reset_link (lk_r.rst_s2),
    .d          ({link.tx_ctl, link.tx_data[NIB_W-1:0]}),
    .q          (neg_half)
  );

  always_comb
  begin
    lk_nxt         = lk_r;
    lk_nxt.rst_s1  = reset;
    lk_nxt.rst_s2  = lk_r.rst_s1;
    lk_nxt.mode_s1 = c_r.mode;
    lk_nxt.mode_s2 = lk_r.mode_s1;
    if (lk_r.mode_s2 == PORT_FULL)
    begin
      lk_nxt.hold     = link.tx_data;
      lk_nxt.toggle   = !lk_r.toggle;
      lk_nxt.first_ok = 1'b0;
    end
    else if (lk_r.mode_s2 == PORT_REDUCED)
    begin
      // A group completes at the rising edge after its falling half
      if (lk_r.first_ok)
      begin
        lk_nxt.hold   = {neg_half, lk_r.first_half};
        lk_nxt.toggle = !lk_r.toggle;
      end
      lk_nxt.first_half = {link.tx_ctl, link.tx_data[NIB_W-1:0]};
      lk_nxt.first_ok   = 1'b1;
    end
    else
    begin
      lk_nxt.first_ok = 1'b0;
    end
    if (lk_r.rst_s2)
    begin
      lk_nxt.mode_s1    = PORT_OFF;
      lk_nxt.mode_s2    = PORT_OFF;
      lk_nxt.first_half = '0;
      lk_nxt.first_ok   = 1'b0;
      lk_nxt.hold       = '0;
      lk_nxt.toggle     = 1'b0;
    end
  end

  always_ff @(posedge link.tenbit_tx_clock)
  begin
    lk_r <= lk_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign link.odd_group_rx_clock  = c_r.phase;
  assign link.even_group_rx_clock = c_r.even_clk;
  assign link.rx_data             = c_r.rx_pins;
  assign link.rx_ctl              = c_r.rx_ctl;
  assign link.comma               = c_r.comma;
  assign rx_group_ready           = take && core_ce && !reset;
  assign tx_group                 = c_r.tx_group;
  assign tx_group_valid           = c_r.tx_valid;
  assign port_mode                = c_r.mode;
endmodule

`default_nettype wire

/* File: tbi_mac_end.sv */
`timescale 1ns/1ps
`default_nettype none

module tbi_mac_end #(
  parameter int TX_HALF = tbi_pkg::TX_HALF_CYCLES
)(
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          core_ce,
  input  wire logic [tbi_pkg::STRAP_W-1:0]   mac_port_type_strap,
  input  wire logic                          tx_clock_run,
  tbi_link_if.mac                            link,
  input  wire logic [tbi_pkg::GROUP_W-1:0]   tx_group,
  input  wire logic                          tx_group_valid,
  output logic                               tx_group_ready,
  output logic      [tbi_pkg::GROUP_W-1:0]   rx_group,
  output logic                               rx_group_valid,
  output logic                               rx_comma
);
  import tbi_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed
  {
    logic [CNT_W-1:0]   cnt;
    logic               phase;
    logic [GROUP_W-1:0] txd;
    logic               tx_ctl;
    logic [GROUP_W-1:0] cur;
    logic               odd_s1;
    logic               odd_s2;
    logic               odd_prev;
    logic               even_s1;
    logic               even_s2;
    logic               even_prev;
    logic [GROUP_W-1:0] dat_s1;
    logic [GROUP_W-1:0] dat_s2;
    logic               ctl_s1;
    logic               ctl_s2;
    logic               com_s1;
    logic               com_s2;
    logic [HALF_W-1:0]  lo_half;
    logic [GROUP_W-1:0] rx_group;
    logic               rx_valid;
    logic               rx_comma;
  } mac_state_t;

  mac_state_t         s_r;
  mac_state_t         s_nxt;
  port_mode_t         mode;
  logic               run;
  logic               launch;
  logic               take;
  logic [GROUP_W-1:0] tx_grp;

  always_comb
  begin
    s_nxt  = s_r;
    mode   = mode_from_strap(mac_port_type_strap);
    // Clock stays low unless user reports gigabit, not negotiating
    run    = tx_clock_run && (mode != PORT_OFF);
    launch = run && (s_r.cnt == CNT_W'(TX_HALF / 2));
    take   = launch && !s_r.phase;
    tx_grp = tx_group_valid ? tx_group : '0;

    // ----------------------------------------
    // Transmit clock divider and launch
    // ----------------------------------------
    if (!run)
    begin
      s_nxt.cnt    = '0;
      s_nxt.phase  = 1'b0;
      s_nxt.txd    = '0;
      s_nxt.tx_ctl = 1'b0;
    end
    else
    begin
      if (s_r.cnt == CNT_W'(TX_HALF - 1))
      begin
        s_nxt.cnt   = '0;
        s_nxt.phase = !s_r.phase;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
      end
      if (launch)
      begin
        if (mode == PORT_FULL)
        begin
          if (!s_r.phase)
          begin
            s_nxt.txd = tx_grp;
          end
        end
        else if (!s_r.phase)
        begin
          s_nxt.cur    = tx_grp;
          s_nxt.txd    = {{(GROUP_W-NIB_W){1'b0}}, tx_grp[NIB_W-1:0]};
          s_nxt.tx_ctl = tx_grp[CTL_LO_BIT];
        end
        else
        begin
          s_nxt.txd    = {{(GROUP_W-NIB_W){1'b0}}, s_r.cur[HI_NIB_LSB +: NIB_W]};
          s_nxt.tx_ctl = s_r.cur[CTL_HI_BIT];
        end
      end
    end

    // ----------------------------------------
    // Receive pins: two flops, then edge detect
    // ----------------------------------------
    s_nxt.odd_s1    = link.odd_group_rx_clock;
    s_nxt.odd_s2    = s_r.odd_s1;
    s_nxt.odd_prev  = s_r.odd_s2;
    s_nxt.even_s1   = link.even_group_rx_clock;
    s_nxt.even_s2   = s_r.even_s1;
    s_nxt.even_prev = s_r.even_s2;
    s_nxt.dat_s1    = link.rx_data;
    s_nxt.dat_s2    = s_r.dat_s1;
    s_nxt.ctl_s1    = link.rx_ctl;
    s_nxt.ctl_s2    = s_r.ctl_s1;
    s_nxt.com_s1    = link.comma;
    s_nxt.com_s2    = s_r.com_s1;
    s_nxt.rx_valid  = 1'b0;

    if (mode == PORT_FULL)
    begin
      if ((s_r.odd_s2 && !s_r.odd_prev) || (s_r.even_s2 && !s_r.even_prev))
      begin
        s_nxt.rx_group = s_r.dat_s2;
        s_nxt.rx_comma = s_r.com_s2;
        s_nxt.rx_valid = 1'b1;
      end
    end
    else if (mode == PORT_REDUCED)
    begin
      if (s_r.odd_s2 && !s_r.odd_prev)
      begin
        s_nxt.lo_half = {s_r.ctl_s2, s_r.dat_s2[NIB_W-1:0]};
      end
      else if (!s_r.odd_s2 && s_r.odd_prev)
      begin
        s_nxt.rx_group = {s_r.ctl_s2, s_r.dat_s2[NIB_W-1:0], s_r.lo_half};
        s_nxt.rx_comma = 1'b0;
        s_nxt.rx_valid = 1'b1;
      end
    end

    if (reset)
    begin
      s_nxt         = '0;
      s_nxt.odd_s1  = link.odd_group_rx_clock;
      s_nxt.odd_s2  = s_r.odd_s1;
      s_nxt.even_s1 = link.even_group_rx_clock;
      s_nxt.even_s2 = s_r.even_s1;
      s_nxt.dat_s1  = link.rx_data;
      s_nxt.dat_s2  = s_r.dat_s1;
      s_nxt.ctl_s1  = link.rx_ctl;
      s_nxt.ctl_s2  = s_r.ctl_s1;
      s_nxt.com_s1  = link.comma;
      s_nxt.com_s2  = s_r.com_s1;
    end
  end

  // Slow pins only: half period must span several core cycles
  always_ff @(posedge core_clk)
  begin
    if (reset || core_ce)
    begin
      s_r <= s_nxt;
    end
  end

  assign link.tenbit_tx_clock = s_r.phase;
  assign link.tx_data         = s_r.txd;
  assign link.tx_ctl          = s_r.tx_ctl;
  assign tx_group_ready       = take && core_ce && !reset;
  assign rx_group             = s_r.rx_group;
  assign rx_group_valid       = s_r.rx_valid;
  assign rx_comma             = s_r.rx_comma;
endmodule

`default_nettype wire

/* File: tbi_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module tbi_link_chk (
  input  wire logic                         core_clk,
  input  wire logic                         reset,
  input  var  tbi_pkg::port_mode_t          port_mode,
  input  wire logic                         tenbit_tx_clock,
  input  wire logic [tbi_pkg::GROUP_W-1:0]  tx_data,
  input  wire logic                         tx_ctl,
  input  wire logic                         odd_group_rx_clock,
  input  wire logic                         even_group_rx_clock,
  input  wire logic [tbi_pkg::GROUP_W-1:0]  rx_data,
  input  wire logic                         rx_ctl,
  input  wire logic                         comma
);
  import tbi_pkg::*;

  // ----------------------------------------
  // Link pin relations
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  logic full_m;
  logic red_m;
  assign full_m = (port_mode == PORT_FULL);
  assign red_m  = (port_mode == PORT_REDUCED);

  // Bench sets every half period to six core cycles
  sequence s_rx_high;
    odd_group_rx_clock [*6] ##1 !odd_group_rx_clock;
  endsequence
  sequence s_tx_low;
    !tenbit_tx_clock [*6];
  endsequence

  a_rx_clk_half: assert property ($rose(odd_group_rx_clock) |-> s_rx_high)
    else $error("receive clock half period wrong");
  a_clk_antiphase: assert property (full_m && (odd_group_rx_clock || even_group_rx_clock)
    |-> odd_group_rx_clock != even_group_rx_clock)
    else $error("receive clocks not in antiphase");
  a_rx_settled: assert property ($changed(odd_group_rx_clock) |-> $stable({rx_ctl, rx_data}) [*2])
    else $error("receive pins move at receive clock edge");
  a_comma_flag: assert property (full_m |-> comma == ((rx_data[6:0] == COMMA_PLUS)
    || (rx_data[6:0] == COMMA_MINUS)))
    else $error("comma flag disagrees with group");
  a_reduced_pins: assert property (red_m |-> !even_group_rx_clock && !comma
    && (rx_data[9:4] == 6'h00) && (tx_data[9:4] == 6'h00))
    else $error("reduced port drives unused pins");
  a_full_ctl: assert property (full_m |-> !rx_ctl && !tx_ctl)
    else $error("control pins active in full port");
  a_off_quiet: assert property (port_mode == PORT_OFF |-> !odd_group_rx_clock && (rx_data == 10'h000))
    else $error("disabled port drives receive pins");
  a_tx_clk_low: assert property ($fell(tenbit_tx_clock) |-> s_tx_low)
    else $error("transmit clock low phase too short");
  a_tx_held: assert property ($rose(tenbit_tx_clock) |-> $stable({tx_ctl, tx_data}) ##1 $stable({tx_ctl, tx_data}))
    else $error("transmit pins move at transmit clock rise");
endmodule

`default_nettype wire

/* File: test_ten_bit_mac_interface.sv */
`timescale 1ns/1ps
`default_nettype none

module test_ten_bit_mac_interface;
  import tbi_pkg::*;

  // ----------------------------------------
  // Stimulus and bookkeeping
  // ----------------------------------------
  localparam int HALF = 6;
  logic               core_clk     = 1'b0;
  logic               reset        = 1'b1;
  logic               dev_reset    = 1'b1;
  logic [2:0]         strap        = 3'h1;
  logic               gigabit_link = 1'b0;
  logic               tx_clock_run = 1'b1;
  logic               send_on      = 1'b0;
  logic [9:0]         m_tx_group   = 10'h17c;
  logic [9:0]         d_rx_group   = 10'h203;
  logic [15:0]        rnd          = 16'h0037;
  logic [9:0]         d_tx_group;
  logic [9:0]         m_rx_group;
  logic [9:0]         exp_g;
  logic               m_tx_ready;
  logic               d_rx_ready;
  logic               d_tx_valid;
  logic               m_rx_valid;
  logic               m_rx_comma;
  port_mode_t         port_mode;
  logic [9:0]         q_up[$];
  logic [9:0]         q_down[$];
  int                 num_errors   = 0;
  int                 checks_done  = 0;
  int                 n_up         = 0;
  int                 n_down       = 0;
  int                 n_rise       = 0;

  tbi_link_if link();

  tbi_mac_end #(.TX_HALF(HALF)) tbi_mac_end_inst (.core_clk(core_clk), .reset(reset), .core_ce(1'b1),
    .mac_port_type_strap(strap), .tx_clock_run(tx_clock_run), .link(link.mac), .tx_group(m_tx_group),
    .tx_group_valid(send_on), .tx_group_ready(m_tx_ready), .rx_group(m_rx_group),
    .rx_group_valid(m_rx_valid), .rx_comma(m_rx_comma));

  // Device reset outlasts the MAC one so the link domain sees clock edges
  tbi_device_end #(.RX_HALF_FULL(HALF), .RX_HALF_RED(HALF)) tbi_device_end_inst (.core_clk(core_clk),
    .reset(dev_reset), .core_ce(1'b1), .mac_port_type_strap(strap), .gigabit_link(gigabit_link),
    .link(link.device), .tx_group(d_tx_group), .tx_group_valid(d_tx_valid), .rx_group(d_rx_group),
    .rx_group_valid(send_on), .rx_group_ready(d_rx_ready), .port_mode(port_mode));

  tbi_link_chk tbi_link_chk_inst (.core_clk(core_clk), .reset(dev_reset), .port_mode(port_mode),
    .tenbit_tx_clock(link.tenbit_tx_clock), .tx_data(link.tx_data), .tx_ctl(link.tx_ctl),
    .odd_group_rx_clock(link.odd_group_rx_clock), .even_group_rx_clock(link.even_group_rx_clock),
    .rx_data(link.rx_data), .rx_ctl(link.rx_ctl), .comma(link.comma));

  always #5 core_clk = ~core_clk;

  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Quarter of groups are commas; never zero, since zero is the idle group
  function automatic logic [9:0] pick(input logic [15:0] v);
    return (v[13:11] == 3'h0) ? {v[2:0], 7'h7c} : (v[13:11] == 3'h1) ? {v[2:0], 7'h03}
      : (v[9:0] == 10'h000) ? 10'h2aa : v[9:0];
  endfunction

  function automatic logic exp_comma(input logic [9:0] g);
    return (g[6:0] == 7'h7c) || (g[6:0] == 7'h03);
  endfunction

  function automatic port_mode_t exp_mode(input logic [2:0] s);
    return (s == 3'h1) ? PORT_FULL : ((s == 3'h5) || (s == 3'h7)) ? PORT_REDUCED : PORT_OFF;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] expv);
    checks_done++;
    if (seen !== expv)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Senders and receivers
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (send_on && m_tx_ready === 1'b1)
    begin
      q_up.push_back(m_tx_group);
      rnd = lfsr(rnd);
      m_tx_group <= pick(rnd);
    end
    if (send_on && d_rx_ready === 1'b1)
    begin
      q_down.push_back(d_rx_group);
      rnd = lfsr(lfsr(rnd));
      d_rx_group <= pick(rnd);
    end
    if (!dev_reset && d_tx_valid === 1'b1)
    begin
      n_up++;
      if (d_tx_group !== 10'h000)
        check("device tx group", d_tx_group, q_up.size() ? q_up.pop_front() : 10'h000);
    end
    if (!dev_reset && m_rx_valid === 1'b1)
    begin
      n_down++;
      if (m_rx_group !== 10'h000)
      begin
        exp_g = q_down.size() ? q_down.pop_front() : 10'h000;
        check("mac rx group", m_rx_group, exp_g);
        if (port_mode == PORT_FULL)
          check("mac comma", m_rx_comma, exp_comma(exp_g));
      end
    end
  end

  always @(posedge link.tenbit_tx_clock) n_rise++;

  // ----------------------------------------
  // Main sequence: every strap pattern
  // ----------------------------------------
  initial
  begin
    for (int s = 0; s < 8; s++)
    begin
      strap <= s[2:0];
      reset <= 1'b1;
      dev_reset <= 1'b1;
      gigabit_link <= 1'b0;
      tx_clock_run <= 1'b1;
      repeat (8) @(posedge core_clk);
      reset <= 1'b0;
      repeat (40) @(posedge core_clk);
      n_up = 0;
      n_down = 0;
      dev_reset <= 1'b0;
      repeat (200) @(posedge core_clk);
      check("port mode", 16'(port_mode), 16'(exp_mode(s[2:0])));
      check("pulses with link down", 16'(n_up + n_down), 16'h0000);
      gigabit_link <= 1'b1;
      repeat (60) @(posedge core_clk);
      send_on <= 1'b1;
      repeat (600) @(posedge core_clk);
      send_on <= 1'b0;
      repeat (100) @(posedge core_clk);
      check("upstream left", 16'(q_up.size()), 16'h0000);
      check("downstream left", 16'(q_down.size()), 16'h0000);
      check("traffic", 16'({n_up > 20, n_down > 20}), (exp_mode(s[2:0]) != PORT_OFF) ? 16'h0003 : 16'h0000);
      tx_clock_run <= 1'b0;
      repeat (30) @(posedge core_clk);
      n_rise = 0;
      repeat (100) @(posedge core_clk);
      check("tx clock rises when stopped", 16'(n_rise), 16'h0000);
      q_up.delete();
      q_down.delete();
    end
    results();
  end

  initial
  begin
    #150000;
    num_errors++;
    results();
  end
endmodule

`default_nettype wire
